// [core/prx_target.sv]
// proximity sensor result registers behind a two-wire serial target
`timescale 1ns/10ps
// How it works
// - answer only at seven-bit address 0x48
// - plain serial writes and reads, master drives
// - three byte registers hold conversion results
// - exposed mean low byte at 0x01
// - dark mean low byte at 0x03
// - 0x02 holds both upper three-bit groups
// - master reads the averages when needed
// - master computes exposed minus dark difference
// - master alone decides near from difference
// - master serial clock at most 400 kbit/s
module prx_target (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // conversion results from the front end
  input  wire logic        result_valid,
  input  wire logic [10:0] exposed_mean,
  input  wire logic [10:0] dark_mean,
  // serial link
  prx_link_if.target       link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                   scl_meta;
  logic                   scl_s;
  logic                   scl_q;
  logic                   sda_meta;
  logic                   sda_s;
  logic                   sda_q;
  prx_pkg::tgt_state_e    state;
  prx_pkg::tgt_state_e    next_state;
  prx_pkg::tgt_state_e    ret;
  prx_pkg::tgt_state_e    next_ret;
  logic                   ack_on;
  logic                   next_ack_on;
  logic [2:0]             bitcnt;
  logic [2:0]             next_bitcnt;
  logic [7:0]             shreg;
  logic [7:0]             next_shreg;
  logic [7:0]             ptr;
  logic [7:0]             next_ptr;
  logic                   sda_oe;
  logic                   next_sda_oe;
  logic [10:0]            exp_live;
  logic [10:0]            next_exp_live;
  logic [10:0]            dark_live;
  logic [10:0]            next_dark_live;
  logic [10:0]            exp_snap;
  logic [10:0]            next_exp_snap;
  logic [10:0]            dark_snap;
  logic [10:0]            next_dark_snap;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_seen;
  logic                   stop_seen;
  logic [7:0]             rd_byte;

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [7:0]  ofs,
                                          input logic [10:0] e,
                                          input logic [10:0] d);
    logic [7:0] r;
    r = prx_pkg::READ_ZERO;
    case (ofs)
      prx_pkg::OFS_EXP_LOW: begin
        r = e[prx_pkg::LOW_W-1:0];
      end
      prx_pkg::OFS_HIGH: begin
        // upper groups side by side, gaps read zero
        r[prx_pkg::HIGH_EXP_LSB +: prx_pkg::HIGH_W] =
          e[prx_pkg::LOW_W +: prx_pkg::HIGH_W];
        r[prx_pkg::HIGH_DARK_LSB +: prx_pkg::HIGH_W] =
          d[prx_pkg::LOW_W +: prx_pkg::HIGH_W];
      end
      prx_pkg::OFS_DARK_LOW: begin
        r = d[prx_pkg::LOW_W-1:0];
      end
      default: begin
        r = prx_pkg::READ_ZERO;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and bus condition detect
  // ----------------------------------------------------------------
  // two flops per pin, a third for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      scl_q    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_meta <= link.scl;
      scl_s    <= scl_meta;
      scl_q    <= scl_s;
      sda_meta <= link.sda;
      sda_s    <= sda_meta;
      sda_q    <= sda_s;
    end
  end

  // start and stop are data edges while the clock stays high
  assign scl_rise   = scl_s && !scl_q;
  assign scl_fall   = !scl_s && scl_q;
  assign start_seen = scl_s && scl_q && sda_q && !sda_s;
  assign stop_seen  = scl_s && scl_q && !sda_q && sda_s;
  assign rd_byte    = reg_read(ptr, exp_snap, dark_snap);

  // ----------------------------------------------------------------
  // serial target sequencer
  // ----------------------------------------------------------------
  // next values for protocol state and result storage
  always_comb begin
    next_state     = state;
    next_ret       = ret;
    next_ack_on    = ack_on;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_ptr       = ptr;
    next_sda_oe    = sda_oe;
    next_exp_live  = exp_live;
    next_dark_live = dark_live;
    next_exp_snap  = exp_snap;
    next_dark_snap = dark_snap;
    if (result_valid) begin
      next_exp_live  = exposed_mean;
      next_dark_live = dark_mean;
    end
    if (stop_seen) begin
      next_state  = prx_pkg::T_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_seen) begin
      // freeze a coherent copy so a multi-byte read never tears
      next_state     = prx_pkg::T_ADDR;
      next_bitcnt    = 3'h0;
      next_ack_on    = 1'b0;
      next_sda_oe    = 1'b0;
      next_exp_snap  = exp_live;
      next_dark_snap = dark_live;
    end else begin
      unique case (state)
        prx_pkg::T_IDLE: begin
          next_sda_oe = 1'b0;
        end
        prx_pkg::T_ADDR, prx_pkg::T_PTR, prx_pkg::T_WR: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == prx_pkg::BIT_LAST) begin
              next_bitcnt = 3'h0;
              next_ack_on = 1'b0;
              next_state  = prx_pkg::T_ACK;
              if (state == prx_pkg::T_ADDR) begin
                if (shreg[6:0] == prx_pkg::DEV_ADDR) begin
                  next_ret = sda_s ? prx_pkg::T_RD : prx_pkg::T_PTR;
                end else begin
                  next_state = prx_pkg::T_IDLE;
                end
              end else if (state == prx_pkg::T_PTR) begin
                next_ptr = {shreg[6:0], sda_s};
                next_ret = prx_pkg::T_WR;
              end else begin
                // data byte dropped, pointer still advances
                next_ptr = ptr + 8'h01;
                next_ret = prx_pkg::T_WR;
              end
            end
          end
        end
        prx_pkg::T_ACK: begin
          if (scl_fall) begin
            if (!ack_on) begin
              next_ack_on = 1'b1;
              next_sda_oe = 1'b1;
            end else begin
              next_ack_on = 1'b0;
              next_state  = ret;
              next_bitcnt = 3'h0;
              next_sda_oe = 1'b0;
              if (ret == prx_pkg::T_RD) begin
                next_shreg  = rd_byte;
                next_sda_oe = !rd_byte[7];
              end
            end
          end
        end
        prx_pkg::T_RD: begin
          if (scl_fall) begin
            if (bitcnt == prx_pkg::BIT_LAST) begin
              next_sda_oe = 1'b0;
              next_state  = prx_pkg::T_MACK;
            end else begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = !shreg[6];
              next_bitcnt = bitcnt + 3'h1;
            end
          end
        end
        prx_pkg::T_MACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              next_state = prx_pkg::T_IDLE; // master ended the read
            end else begin
              next_ptr    = ptr + 8'h01;
              next_state  = prx_pkg::T_ACK;
              next_ack_on = 1'b1;
              next_ret    = prx_pkg::T_RD;
            end
          end
        end
        default: begin
          next_state  = prx_pkg::T_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // registers clear at power-on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= prx_pkg::T_IDLE;
      ret       <= prx_pkg::T_IDLE;
      ack_on    <= 1'b0;
      bitcnt    <= 3'h0;
      shreg     <= 8'h00;
      ptr       <= 8'h00;
      sda_oe    <= 1'b0;
      exp_live  <= prx_pkg::MEAN_RESET;
      dark_live <= prx_pkg::MEAN_RESET;
      exp_snap  <= prx_pkg::MEAN_RESET;
      dark_snap <= prx_pkg::MEAN_RESET;
    end else begin
      state     <= next_state;
      ret       <= next_ret;
      ack_on    <= next_ack_on;
      bitcnt    <= next_bitcnt;
      shreg     <= next_shreg;
      ptr       <= next_ptr;
      sda_oe    <= next_sda_oe;
      exp_live  <= next_exp_live;
      dark_live <= next_dark_live;
      exp_snap  <= next_exp_snap;
      dark_snap <= next_dark_snap;
    end
  end

  // open drain: only ever pulls low
  assign link.sda_dev_o  = 1'b0;
  assign link.sda_dev_oe = sda_oe;

endmodule // prx_target

// [core/prx_pkg.sv]
// shared constants and types for the proximity result readout
package prx_pkg;

  // ----------------------------------------------------------------
  // serial target identity and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR      = 7'h48;
  localparam logic [7:0] OFS_EXP_LOW   = 8'h01;
  localparam logic [7:0] OFS_HIGH      = 8'h02;
  localparam logic [7:0] OFS_DARK_LOW  = 8'h03;
  localparam logic [7:0] READ_ZERO     = 8'h00;
  localparam int         MEAN_W        = 11;
  localparam int         LOW_W         = 8;
  localparam int         HIGH_W        = 3;
  localparam int         HIGH_EXP_LSB  = 4;
  localparam int         HIGH_DARK_LSB = 0;
  localparam logic [10:0] MEAN_RESET   = 11'h000;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  // ----------------------------------------------------------------
  // timing at the 40 MHz system clock
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 25;
  localparam int SCL_MAX_KHZ   = 400;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  localparam int QTR_CYC       = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int QTR_W         = $clog2(QTR_CYC);

  // ----------------------------------------------------------------
  // controller registers on the system bus
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_THRESH  = 8'h04;
  localparam logic [7:0] A_STATUS  = 8'h08;
  localparam logic [7:0] A_MEANS   = 8'h0c;
  localparam logic [7:0] A_DIFF    = 8'h10;
  localparam int CTRL_GO           = 0;
  localparam int ST_BUSY           = 0;
  localparam int ST_NEAR           = 1;
  localparam int ST_NACK           = 2;
  localparam int ST_DONE           = 3;
  localparam int MEANS_EXP_LSB     = 16;
  localparam int DIFF_W            = 12;
  localparam logic [11:0] THRESH_RESET = 12'h000;

  // ----------------------------------------------------------------
  // controller transaction script
  // ----------------------------------------------------------------
  localparam logic [3:0] STEP_RD_FIRST = 4'h5;
  localparam logic [3:0] STEP_RD_LAST  = 4'h7;
  localparam logic [3:0] STEP_STOP     = 4'h8;
  localparam logic [3:0] BITS_ACK      = 4'h8;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_STOP  = 2'b11
  } op_e;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_ADDR = 3'b001,
    T_PTR  = 3'b010,
    T_WR   = 3'b011,
    T_ACK  = 3'b100,
    T_RD   = 3'b101,
    T_MACK = 3'b110
  } tgt_state_e;

endpackage

// [core/prx_link_if.sv]
// two-wire link between the controller and the proximity target
`timescale 1ns/10ps
interface prx_link_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;

  // open-drain wire: low when any enabled driver pulls low
  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

  modport target (
    input  scl,
    input  sda,
    output sda_dev_o,
    output sda_dev_oe
  );

  modport controller (
    output scl,
    output sda_host_o,
    output sda_host_oe,
    input  sda
  );
endinterface // prx_link_if

// [core/prx_controller.sv]
// bus-controlled readout master for the proximity target
`timescale 1ns/10ps
module prx_controller (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial link
  prx_link_if.controller   link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // quarter-bit counter width and terminal count
  localparam int            QW       = prx_pkg::QTR_W;
  localparam logic [QW-1:0] QTR_LAST = QW'(prx_pkg::QTR_CYC - 1);

  logic                    sda_meta;
  logic                    sda_s;
  logic                    ap_we;
  logic [7:0]              ap_addr;
  logic [11:0]             thresh;
  logic [11:0]             next_thresh;
  logic [31:0]             next_hrdata;
  logic                    busy;
  logic                    next_busy;
  logic                    done;
  logic                    next_done;
  logic                    nack;
  logic                    next_nack;
  logic                    near;
  logic                    next_near;
  logic [11:0]             diff;
  logic [11:0]             next_diff;
  logic [QW-1:0]           qcnt;
  logic [QW-1:0]           next_qcnt;
  logic [1:0]              quarter;
  logic [1:0]              next_quarter;
  logic [3:0]              bitn;
  logic [3:0]              next_bitn;
  logic [3:0]              step;
  logic [3:0]              next_step;
  logic [7:0]              shreg;
  logic [7:0]              next_shreg;
  logic                    scl;
  logic                    next_scl;
  logic                    sda_low;
  logic                    next_sda_low;
  logic [7:0]              rbyte [3];
  logic [7:0]              next_rbyte [3];
  logic [10:0]             exp_m;
  logic [10:0]             dark_m;
  logic                    tick;
  logic                    access;
  prx_pkg::op_e            op;

  // operation and byte for each step of the read script
  function automatic prx_pkg::op_e op_of(input logic [3:0] s);
    case (s)
      4'h0, 4'h3: return prx_pkg::OP_START;
      4'h1, 4'h2, 4'h4: return prx_pkg::OP_WRITE;
      prx_pkg::STEP_STOP: return prx_pkg::OP_STOP;
      default: return prx_pkg::OP_READ;
    endcase
  endfunction

  function automatic logic [7:0] byte_of(input logic [3:0] s);
    case (s)
      4'h1: return {prx_pkg::DEV_ADDR, 1'b0};
      4'h2: return prx_pkg::OFS_EXP_LOW;
      4'h4: return {prx_pkg::DEV_ADDR, 1'b1};
      default: return 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // sda synchroniser and derived values
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
    end else begin
      sda_meta <= link.sda;
      sda_s    <= sda_meta;
    end
  end

  assign op     = op_of(step);
  assign tick   = busy && (qcnt == QTR_LAST);
  assign access = hsel && htrans[1] && hready;
  assign exp_m  = {rbyte[1][prx_pkg::HIGH_EXP_LSB +: prx_pkg::HIGH_W], rbyte[0]};
  assign dark_m = {rbyte[1][prx_pkg::HIGH_DARK_LSB +: prx_pkg::HIGH_W], rbyte[2]};

  // ----------------------------------------------------------------
  // register slave and serial sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_thresh  = thresh;
    next_hrdata  = hrdata;
    next_busy    = busy;
    next_done    = done;
    next_nack    = nack;
    next_near    = near;
    next_diff    = diff;
    next_qcnt    = qcnt;
    next_quarter = quarter;
    next_bitn    = bitn;
    next_step    = step;
    next_shreg   = shreg;
    next_scl     = scl;
    next_sda_low = sda_low;
    next_rbyte   = rbyte;
    // read data is captured in the address phase
    if (access && !hwrite) begin
      case (haddr)
        prx_pkg::A_THRESH: next_hrdata = {20'h00000, thresh};
        prx_pkg::A_STATUS: next_hrdata = {28'h0000000, done, nack, near, busy};
        prx_pkg::A_MEANS: next_hrdata = {5'h00, exp_m, 5'h00, dark_m};
        prx_pkg::A_DIFF: next_hrdata = {{20{diff[11]}}, diff};
        default: next_hrdata = 32'h00000000;
      endcase
    end
    // writes land in the data phase
    if (ap_we && ap_addr == prx_pkg::A_THRESH) begin
      next_thresh = hwdata[11:0];
    end
    if (ap_we && ap_addr == prx_pkg::A_CTRL && hwdata[prx_pkg::CTRL_GO] && !busy) begin
      next_busy  = 1'b1;
      next_done  = 1'b0;
      next_nack  = 1'b0;
      next_step  = 4'h0;
      next_bitn  = 4'h0;
      next_qcnt  = '0;
      next_quarter = 2'h0;
    end
    if (busy) begin
      next_qcnt = tick ? '0 : qcnt + QW'(1);
    end
    if (tick) begin
      next_quarter = quarter + 2'h1;
      unique case (quarter)
        2'h0: next_scl = 1'b0;
        2'h1: begin
          unique case (op)
            prx_pkg::OP_START: next_sda_low = 1'b0;
            prx_pkg::OP_STOP: next_sda_low = 1'b1;
            prx_pkg::OP_WRITE: next_sda_low = (bitn != prx_pkg::BITS_ACK) && !shreg[7];
            prx_pkg::OP_READ: next_sda_low = (bitn == prx_pkg::BITS_ACK) &&
                                             (step != prx_pkg::STEP_RD_LAST);
          endcase
        end
        2'h2: next_scl = 1'b1;
        2'h3: begin
          next_shreg = {shreg[6:0], sda_s};
          next_bitn  = bitn + 4'h1;
          if (op == prx_pkg::OP_START) begin
            next_sda_low = 1'b1;
          end else if (op == prx_pkg::OP_STOP) begin
            next_sda_low = 1'b0;
          end
          if (op == prx_pkg::OP_START || bitn == prx_pkg::BITS_ACK) begin
            next_bitn = 4'h0;
            if (op == prx_pkg::OP_READ) begin
              next_rbyte[2'(step - prx_pkg::STEP_RD_FIRST)] = shreg;
            end
            next_step = step + 4'h1;
            if (op == prx_pkg::OP_WRITE && sda_s) begin
              next_nack = 1'b1; // abort to stop on missing ack
              next_step = prx_pkg::STEP_STOP;
            end
            next_shreg = byte_of(next_step);
          end
          if (op == prx_pkg::OP_STOP) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_bitn = 4'h0;
            next_diff = diff_calc(exp_m, dark_m);
            next_near = !nack && ($signed(next_diff) > $signed(thresh));
          end
        end
      endcase
    end
  end

  // twelve bits wide so the sign of the difference survives
  function automatic logic [11:0] diff_calc(input logic [10:0] e, input logic [10:0] d);
    return {1'b0, e} - {1'b0, d};
  endfunction

  // all controller state resets; scl, hreadyout and the sda synchroniser come up high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_we     <= 1'b0;
      ap_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      thresh    <= prx_pkg::THRESH_RESET;
      busy      <= 1'b0;
      done      <= 1'b0;
      nack      <= 1'b0;
      near      <= 1'b0;
      diff      <= 12'h000;
      qcnt      <= '0;
      quarter   <= 2'h0;
      bitn      <= 4'h0;
      step      <= 4'h0;
      shreg     <= 8'h00;
      scl       <= 1'b1;
      sda_low   <= 1'b0;
      rbyte     <= '{default: 8'h00};
    end else begin
      ap_we     <= access && hwrite;
      ap_addr   <= haddr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      thresh    <= next_thresh;
      busy      <= next_busy;
      done      <= next_done;
      nack      <= next_nack;
      near      <= next_near;
      diff      <= next_diff;
      qcnt      <= next_qcnt;
      quarter   <= next_quarter;
      bitn      <= next_bitn;
      step      <= next_step;
      shreg     <= next_shreg;
      scl       <= next_scl;
      sda_low   <= next_sda_low;
      rbyte     <= next_rbyte;
    end
  end

  assign link.scl         = scl;
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = sda_low;

endmodule // prx_controller

// [sim/prx_link_asserts.sv]
// concurrent checks on the two-wire link between controller and target
`timescale 1ns/10ps
module prx_link_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link wires
  input wire logic scl,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // link timing and ownership
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // each scl half-bit lasts two quarters of 25 cycles
  sequence scl_hi_run; scl [*8]; endsequence
  sequence scl_lo_run; !scl [*8]; endsequence

  AST_SCL_HIGH: assert property ($rose(scl) |=> scl_hi_run)
    else $error("scl high phase too short");
  AST_SCL_LOW: assert property ($fell(scl) |=> scl_lo_run)
    else $error("scl low phase too short");
  AST_SCL_RISE: assert property ($fell(scl) |-> ##[40:60] $rose(scl))
    else $error("scl low phase not two quarters");
  AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("target changed sda while scl high");
  AST_START_BY_HOST: assert property (scl && $past(scl) && $fell(sda) |-> sda_host_oe)
    else $error("start condition not made by the controller");
  AST_STOP_BY_HOST: assert property (scl && $past(scl) && $rose(sda) |-> $past(sda_host_oe))
    else $error("stop condition not made by the controller");
  AST_DEV_RELEASE: assert property ($rose(sda_dev_oe) |-> ##[1:1000] !sda_dev_oe)
    else $error("target holds sda too long");
  AST_RESET_IDLE: assert property ($rose(hresetn) |-> scl && !sda_dev_oe && !sda_host_oe)
    else $error("link not idle after reset");
endmodule // prx_link_asserts

// [sim/proximity_adc_result_readout_tb.sv]
// self-checking bench for controller and target joined over the link
`timescale 1ns/10ps
module proximity_adc_result_readout_tb;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, result_valid;
  logic [7:0]  haddr, sh;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, seen;
  logic [10:0] exposed_mean, dark_mean;
  logic [31:0] exp_q[$];
  int          miscompares = 0, checks_done = 0, cycles = 0, nbit = 0, starts = 0;
  event        got;
  prx_link_if link();
  prx_target i_prx_target (.hclk(hclk), .hresetn(hresetn), .result_valid(result_valid),
    .exposed_mean(exposed_mean), .dark_mean(dark_mean), .link(link));
  prx_controller i_prx_controller (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
  prx_link_asserts i_prx_link_asserts (.hclk(hclk), .hresetn(hresetn), .scl(link.scl),
    .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe), .sda(link.sda));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one single word transfer; address phase held until hready
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // read and hand the result to the watcher with its expectation
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0, r);
    check({31'h0, hresp}, 32'h0);
    seen = r;
    -> got;
  endtask

  // ----------------------------------------------------------------
  // clock, watchers and ceiling
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // compares each read result with the oldest expectation
  initial forever begin
    @(got);
    check(seen, exp_q.pop_front());
  end
  // a start condition restarts the bit count on the wire
  always @(negedge link.sda) if (link.scl === 1'b1) begin
    starts++;
    nbit = 0;
  end
  // first byte after a start carries address and direction
  always @(posedge link.scl) begin
    sh = {sh[6:0], link.sda};
    nbit++;
    if (nbit == 8) check({24'h0, sh}, (starts % 2) ? 32'h90 : 32'h91);
  end
  // cuts a hang short
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [10:0] e, d;
    logic [11:0] th, df;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    result_valid = 1'b0;
    exposed_mean = 11'h000;
    dark_mean = 11'h000;
    void'($urandom(64178));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(prx_pkg::A_MEANS, 32'h0);
    rd_chk(prx_pkg::A_STATUS, 32'h0);
    rd_chk(8'h14, 32'h0);
    for (int i = 0; i < 4; i++) begin
      e = (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : 11'($urandom);
      d = (i == 1) ? 11'h7ff : 11'($urandom);
      th = 12'($urandom % 64) - 12'h020;
      exposed_mean <= e;
      dark_mean <= d;
      result_valid <= 1'b1;
      xfer(prx_pkg::A_THRESH, 1'b1, {20'h0, th}, r);
      result_valid <= 1'b0;
      xfer(prx_pkg::A_CTRL, 1'b1, 32'h1, r);
      do xfer(prx_pkg::A_STATUS, 1'b0, 32'h0, r); while (r[0] !== 1'b1);
      do xfer(prx_pkg::A_STATUS, 1'b0, 32'h0, r); while (r[0] !== 1'b0);
      df = {1'b0, e} - {1'b0, d};
      xfer(prx_pkg::A_MEANS, 1'b1, 32'hffffffff, r);
      rd_chk(prx_pkg::A_MEANS, {5'h0, e, 5'h0, d});
      rd_chk(prx_pkg::A_DIFF, {{20{df[11]}}, df});
      rd_chk(prx_pkg::A_STATUS, {28'h0, 2'b10, $signed(df) > $signed(th), 1'b0});
    end
    // a reset in mid-run clears results and status again
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(prx_pkg::A_MEANS, 32'h0);
    rd_chk(prx_pkg::A_STATUS, 32'h0);
    @(posedge hclk);
    end_of_test();
  end
endmodule // proximity_adc_result_readout_tb
